// ### core/cpu_reset_interrupt_entry.sv
`timescale 1ns/1ps
// reset and interrupt entry sequencer for the 8-bit core
module cpu_reset_interrupt_entry (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [cpu_entry_pkg::NUM_RST_SRC-1:0] i_rst_src,
  input wire logic i_lvd_en,
  input wire logic i_det_busy,
  input wire logic i_rst_pin_n,
  input wire logic [cpu_entry_pkg::NUM_IRQ-1:0] i_irq_pend,
  input wire logic i_insn_boundary,
  input wire logic i_swi_req,
  input wire logic i_rti_req,
  input wire logic i_ccr_wr,
  input wire logic [7:0] i_ccr_wdata,
  input wire cpu_entry_pkg::ctx_t i_ctx,
  input wire logic [7:0] i_rdata,
  output cpu_entry_pkg::bus_req_t o_bus,
  output logic o_abort,
  output logic o_periph_reset,
  output logic o_pins_hiz,
  output logic o_busy,
  output logic o_run,
  output logic o_queue_valid,
  output logic o_ctx_load,
  output cpu_entry_pkg::ctx_t o_ctx,
  output logic [15:0] o_stack_pointer,
  output logic [7:0] o_condition_code_reg,
  output logic [cpu_entry_pkg::NUM_RST_SRC-1:0] o_reset_source_status
);
  typedef enum logic [8:0] {
    S_RESET = 9'h001,
    S_IDLE = 9'h002,
    S_PUSH = 9'h004,
    S_VHI = 9'h008,
    S_VLO = 9'h010,
    S_FREE = 9'h020,
    S_FILL = 9'h040,
    S_PULL = 9'h080,
    S_RDONE = 9'h100
  } state_t;

  state_t state;
  state_t next_state;
  logic in_reset;
  logic irq_any;
  logic [15:0] irq_vec;
  logic [15:0] vec_addr;
  logic [15:0] vec_base;
  logic [2:0] step;
  logic from_reset;
  logic [7:0] pull_buf [0:3];
  logic irq_take;
  logic swi_take;

  reset_source_capture u_src (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_src(i_rst_src),
    .i_lvd_en(i_lvd_en),
    .i_det_busy(i_det_busy),
    .i_rst_pin_n(i_rst_pin_n),
    .o_in_reset(in_reset),
    .o_status(o_reset_source_status)
  );

  irq_priority u_pri (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pend(i_irq_pend),
    .o_any(irq_any),
    .o_vec(irq_vec)
  );

  function automatic logic [7:0] ctx_byte(input cpu_entry_pkg::ctx_t c, input logic [2:0] n);
    logic [7:0] b;
    case (n)
      3'h0: b = c.pc[7:0];
      3'h1: b = c.pc[15:8];
      3'h2: b = c.idx_low;
      3'h3: b = c.acc;
      default: b = c.condition_code_reg;
    endcase
    return b;
  endfunction

  // nested entry allowed whenever the mask bit is clear
  assign irq_take = i_insn_boundary & irq_any &
    ~o_condition_code_reg[cpu_entry_pkg::CCR_I_BIT]; // RULE9 RULE18
  assign swi_take = i_insn_boundary & i_swi_req; // RULE17

  always_comb begin
    next_state = state;
    case (state)
      S_RESET: if (!in_reset) next_state = S_VHI; // RULE2 RULE3
      S_IDLE: begin
        if (i_rti_req && i_insn_boundary) begin
          next_state = S_PULL;
        end else if (swi_take || irq_take) begin
          next_state = S_PUSH;
        end
      end
      S_PUSH: if (step == 3'h4) next_state = S_VHI;
      S_VHI: next_state = S_VLO;
      S_VLO: next_state = S_FREE;
      S_FREE: next_state = S_FILL; // RULE14
      S_FILL: if (step == cpu_entry_pkg::FILL_BYTES - 3'h1) next_state = S_IDLE;
      S_PULL: if (step == 3'h4) next_state = S_RDONE;
      S_RDONE: next_state = S_IDLE;
      default: next_state = S_RESET;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset) begin
      state <= S_RESET; // RULE1
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset || next_state != state) begin
      step <= 3'h0;
    end else begin
      step <= step + 3'h1;
    end
  end

  // vector pick and fetch, high byte first
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset) begin
      vec_base <= cpu_entry_pkg::RESET_VEC_HI;
      vec_addr <= '0;
      from_reset <= 1'b1;
    end else begin
      if (state == S_IDLE && next_state == S_PUSH) begin
        vec_base <= swi_take ? cpu_entry_pkg::SWI_VEC_HI : irq_vec; // RULE10 RULE17
        from_reset <= 1'b0;
      end
      if (state == S_VHI) vec_addr[15:8] <= i_rdata; // RULE13
      if (state == S_VLO) vec_addr[7:0] <= i_rdata; // RULE13
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset) begin
      o_bus <= '0;
    end else begin
      o_bus <= '0;
      case (next_state)
        S_PUSH: begin
          o_bus.wr <= 1'b1;
          o_bus.addr <= (state == S_PUSH) ? o_stack_pointer - 16'h0001 : o_stack_pointer;
          o_bus.wdata <= ctx_byte(i_ctx, (state == S_PUSH) ? step + 3'h1 : 3'h0); // RULE11 RULE16
        end
        S_VHI: begin
          o_bus.rd <= 1'b1;
          o_bus.addr <= (state == S_RESET) ? cpu_entry_pkg::RESET_VEC_HI : vec_base;
        end
        S_VLO: begin
          o_bus.rd <= 1'b1;
          o_bus.addr <= from_reset ? cpu_entry_pkg::RESET_VEC_LO : vec_base + 16'h0001;
        end
        S_FILL: begin
          o_bus.rd <= 1'b1; // RULE15
          o_bus.addr <= (state == S_FILL) ? o_bus.addr + 16'h0001 : vec_addr;
        end
        S_PULL: begin
          o_bus.rd <= 1'b1;
          o_bus.addr <= (state == S_PULL) ? o_bus.addr + 16'h0001 : o_stack_pointer + 16'h0001;
        end
        default: o_bus <= '0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset) begin
      o_stack_pointer <= cpu_entry_pkg::STACK_RESET; // RULE5
    end else if (state == S_PUSH) begin
      o_stack_pointer <= o_stack_pointer - 16'h0001;
    end else if (state == S_PULL) begin
      o_stack_pointer <= o_stack_pointer + 16'h0001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset) begin
      o_condition_code_reg <= cpu_entry_pkg::CCR_RESET; // RULE4
    end else if (state == S_PUSH && step == 3'h4) begin
      o_condition_code_reg[cpu_entry_pkg::CCR_I_BIT] <= 1'b1; // RULE12
    end else if (state == S_RDONE) begin
      o_condition_code_reg <= pull_buf[0];
    end else if (i_ccr_wr && state == S_IDLE) begin
      o_condition_code_reg <= i_ccr_wdata;
    end
  end

  // pop order ccr, a, x, pch, pcl
  always_ff @(posedge i_sys_clk) begin
    if (state == S_PULL && step != 3'h4) begin
      pull_buf[step[1:0]] <= i_rdata; // RULE19
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset) begin
      o_ctx <= '0;
      o_ctx_load <= 1'b0;
    end else begin
      o_ctx_load <= (state == S_RDONE);
      if (state == S_PULL && step == 3'h4) begin
        o_ctx.condition_code_reg <= pull_buf[0];
        o_ctx.acc <= pull_buf[1];
        o_ctx.idx_low <= pull_buf[2];
        o_ctx.pc <= {pull_buf[3], i_rdata};
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset) begin
      o_abort <= 1'b1; // RULE1
      o_periph_reset <= 1'b1; // RULE6
      o_pins_hiz <= 1'b1; // RULE6
      o_busy <= 1'b1;
      o_run <= 1'b0;
      o_queue_valid <= 1'b0;
    end else begin
      o_abort <= 1'b0;
      o_periph_reset <= 1'b0;
      o_pins_hiz <= 1'b0;
      o_busy <= (next_state != S_IDLE);
      o_run <= (next_state == S_IDLE);
      o_queue_valid <= (state == S_FILL && next_state == S_IDLE);
    end
  end

  // helper for reset sequence length
  logic [3:0] rst_cyc;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || in_reset) begin
      rst_cyc <= '0;
    end else if (from_reset && state != S_RESET && state != S_IDLE) begin
      rst_cyc <= rst_cyc + 4'h1;
    end
  end

  sequence vec_pair_s;
    o_bus.rd ##1 o_bus.rd;
  endsequence

  sequence free_then_fill_s;
    !o_bus.rd && !o_bus.wr ##1 o_bus.rd [*3];
  endsequence

  reset_regs_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(in_reset) |=> o_stack_pointer == cpu_entry_pkg::STACK_RESET
      && o_condition_code_reg[cpu_entry_pkg::CCR_I_BIT]) // RULE4 RULE5
    else $error("reset did not load stack and mask");
  reset_abort_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    in_reset |=> o_abort && o_pins_hiz && o_periph_reset && !o_run) // RULE1 RULE6
    else $error("reset did not abort");
  reset_len_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || in_reset)
    $rose(o_run) && from_reset |-> rst_cyc == 4'(cpu_entry_pkg::RESET_SEQ_CYCLES)) // RULE3
    else $error("reset sequence not six cycles");
  reset_vec_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || in_reset)
    $fell(o_abort) |-> o_bus.rd && o_bus.addr == cpu_entry_pkg::RESET_VEC_HI) // RULE3 RULE13
    else $error("reset vector fetch wrong");
  push_order_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || in_reset)
    state == S_IDLE && next_state == S_PUSH |=>
      o_bus.wr && o_bus.wdata == $past(i_ctx.pc[7:0])) // RULE11 RULE16
    else $error("first push is not pc low");
  mask_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || in_reset)
    state == S_PUSH && step == 3'h4 |=>
      o_condition_code_reg[cpu_entry_pkg::CCR_I_BIT] ##0 vec_pair_s) // RULE12 RULE13
    else $error("mask not set before vector fetch");
  idle_cycle_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || in_reset)
    state == S_VLO |=> free_then_fill_s) // RULE14 RULE15
    else $error("free cycle or fill wrong");
  masked_irq_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || in_reset)
    state == S_IDLE && !i_swi_req && !i_rti_req &&
      o_condition_code_reg[cpu_entry_pkg::CCR_I_BIT] |=> state == S_IDLE) // RULE9 RULE18
    else $error("masked interrupt was taken");
  swi_take_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || in_reset)
    state == S_IDLE && i_swi_req && i_insn_boundary && !i_rti_req |=>
      state == S_PUSH ##5 o_bus.addr == cpu_entry_pkg::SWI_VEC_HI) // RULE17 RULE10
    else $error("software trap not taken");
  status_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(in_reset) |-> o_reset_source_status != '0) // RULE7 RULE8
    else $error("reset source not recorded");
  pull_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || in_reset)
    state == S_RDONE |=> o_ctx_load && o_stack_pointer == $past(o_stack_pointer)) // RULE19
    else $error("return pop not finished");
endmodule // cpu_reset_interrupt_entry

// ### core/cpu_entry_pkg.sv
// constants and carrier types for the cpu reset and interrupt entry sequencer
// What this block does
// RULE1: reset aborts current operation immediately
// RULE2: reset ends when sources done, pin released
// RULE3: six-cycle reset vector fetch and queue fill
// RULE4: reset sets interrupt mask bit
// RULE5: reset loads stack pointer with 0x00ff
// RULE6: reset initialises control, peripherals off, pins hi-z
// RULE7: seven reset sources produce reset
// RULE8: status records most recent reset source
// RULE9: interrupt waits for instruction boundary
// RULE10: vector from highest pending at entry start
// RULE11: push pcl, pch, x, a, ccr in order
// RULE12: mask set after condition codes stacked
// RULE13: vector fetched high byte first
// RULE14: one idle bus cycle after vector fetch
// RULE15: fetch three program bytes from vector
// RULE16: index high byte never stacked
// RULE17: software trap ignores interrupt mask
// RULE18: cleared mask allows nested interrupts
// RULE19: return pops ccr, a, x, pch, pcl
package cpu_entry_pkg;
  localparam int NUM_IRQ = 8;
  localparam logic [15:0] RESET_VEC_HI = 16'hfffe;
  localparam logic [15:0] RESET_VEC_LO = 16'hffff;
  localparam logic [15:0] SWI_VEC_HI = 16'hfffc;
  localparam logic [15:0] IRQ_VEC_TOP = 16'hfffa;
  localparam logic [15:0] STACK_RESET = 16'h00ff;
  localparam logic [7:0] CCR_RESET = 8'h68;
  localparam int CCR_I_BIT = 3;
  localparam logic [2:0] FILL_BYTES = 3'h3;
  localparam int RESET_SEQ_CYCLES = 6;
  localparam int NUM_RST_SRC = 7;
  // reset source bit positions
  localparam int SRC_POR = 0;
  localparam int SRC_LVD = 1;
  localparam int SRC_PIN = 2;
  localparam int SRC_WDOG = 3;
  localparam int SRC_ILOP = 4;
  localparam int SRC_ILAD = 5;
  localparam int SRC_DBG = 6;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] condition_code_reg;
    logic [7:0] acc;
    logic [7:0] idx_low;
    logic [15:0] pc;
  } ctx_t;
endpackage

// ### core/reset_source_capture.sv
`timescale 1ns/1ps
// reset source synchroniser, combiner and status register
module reset_source_capture (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [cpu_entry_pkg::NUM_RST_SRC-1:0] i_src,
  input wire logic i_lvd_en,
  input wire logic i_det_busy,
  input wire logic i_rst_pin_n,
  output logic o_in_reset,
  output logic [cpu_entry_pkg::NUM_RST_SRC-1:0] o_status
);
  logic [cpu_entry_pkg::NUM_RST_SRC-1:0] src_s1;
  logic [cpu_entry_pkg::NUM_RST_SRC-1:0] src_s2;
  logic [1:0] pin_s;
  logic [1:0] busy_s;
  logic [cpu_entry_pkg::NUM_RST_SRC-1:0] eff;

  always_ff @(posedge i_sys_clk) begin
    src_s1 <= i_src;
    src_s2 <= src_s1;
    pin_s <= {pin_s[0], i_rst_pin_n};
    busy_s <= {busy_s[0], i_det_busy};
  end

  always_comb begin
    eff = src_s2; // RULE7
    eff[cpu_entry_pkg::SRC_LVD] = src_s2[cpu_entry_pkg::SRC_LVD] & i_lvd_en;
    eff[cpu_entry_pkg::SRC_PIN] = ~pin_s[1];
  end

  // held in reset while any source, detection, or pin is active
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_in_reset <= 1'b1;
    end else begin
      o_in_reset <= (|eff) | busy_s[1]; // RULE2
    end
  end

  // latch sources seen during a reset event; a new event replaces old record
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_status <= '0;
    end else if (|eff) begin
      if (!o_in_reset) begin
        o_status <= eff; // RULE8
      end else begin
        o_status <= o_status | eff;
      end
    end
  end
endmodule // reset_source_capture

// ### core/irq_priority.sv
`timescale 1ns/1ps
// fixed priority selection of pending interrupt, lowest index wins
module irq_priority (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [cpu_entry_pkg::NUM_IRQ-1:0] i_pend,
  output logic o_any,
  output logic [15:0] o_vec
);
  function automatic logic [15:0] vec_of(input logic [cpu_entry_pkg::NUM_IRQ-1:0] p);
    logic [15:0] v;
    v = cpu_entry_pkg::IRQ_VEC_TOP;
    for (int k = cpu_entry_pkg::NUM_IRQ - 1; k >= 0; k--) begin
      if (p[k]) begin
        v = cpu_entry_pkg::IRQ_VEC_TOP - 16'(2 * k);
      end
    end
    return v;
  endfunction

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_any <= 1'b0;
      o_vec <= cpu_entry_pkg::IRQ_VEC_TOP;
    end else begin
      o_any <= |i_pend;
      o_vec <= vec_of(i_pend);
    end
  end
endmodule // irq_priority

// ### dv/mem_bus_model.sv
`timescale 1ns/1ps
// memory bus partner: zero-wait reads from a fixed address pattern
module mem_bus_model (
  input wire logic i_sys_clk,
  input wire cpu_entry_pkg::bus_req_t i_bus,
  output logic [7:0] o_rdata
);
  logic [7:0] idle_pat = 8'h00;
  // bus not driven outside reads: pattern moves every cycle
  always @(posedge i_sys_clk) begin
    idle_pat <= idle_pat + 8'h3d;
  end
  always_comb begin
    o_rdata = i_bus.rd ? (i_bus.addr[7:0] ^ 8'h5a) : idle_pat;
  end
endmodule // mem_bus_model

// ### dv/cpu_reset_interrupt_entry_test.sv
`timescale 1ns/1ps
// self-checking bench for the reset and interrupt entry sequencer
module cpu_reset_interrupt_entry_test;
  typedef struct packed {logic [7:0] pend; logic [15:0] vec;} row_t;
  logic clk = 1'b0, rst = 1'b1, lvd_en = 1'b1, det_busy = 1'b0, pin_n = 1'b1;
  logic bnd = 1'b1, software_trap = 1'b0, return_from_interrupt = 1'b0, ccr_wr = 1'b0;
  logic [6:0] rst_src = 7'h00;
  logic [7:0] pend = 8'h00, ccr_wdata = 8'h00, rdata;
  cpu_entry_pkg::ctx_t ctx = '{condition_code_reg:8'h60, acc:8'h11, idx_low:8'h22, pc:16'h3344};
  cpu_entry_pkg::ctx_t octx, ctx_seen;
  cpu_entry_pkg::bus_req_t bus;
  cpu_entry_pkg::bus_req_t got[$], exp_q[$];
  logic abort, periph, hiz, busy, run, qv, ctx_load;
  logic [15:0] sp, sp_e;
  logic [7:0] condition_code_reg;
  logic [6:0] status;
  int error_cnt = 0, compares = 0, qv_cnt = 0;
  row_t rows[4] = '{'{8'h01, 16'hfffa}, '{8'h06, 16'hfff8}, '{8'h28, 16'hfff4},
    '{8'h80, 16'hffec}};
  always #50 clk = ~clk;
  cpu_reset_interrupt_entry u_cpu_reset_interrupt_entry (.i_sys_clk(clk), .i_rst(rst),
    .i_rst_src(rst_src), .i_lvd_en(lvd_en), .i_det_busy(det_busy), .i_rst_pin_n(pin_n),
    .i_irq_pend(pend), .i_insn_boundary(bnd), .i_swi_req(software_trap), .i_rti_req(return_from_interrupt),
    .i_ccr_wr(ccr_wr), .i_ccr_wdata(ccr_wdata), .i_ctx(ctx), .i_rdata(rdata), .o_bus(bus),
    .o_abort(abort), .o_periph_reset(periph), .o_pins_hiz(hiz), .o_busy(busy), .o_run(run),
    .o_queue_valid(qv), .o_ctx_load(ctx_load), .o_ctx(octx), .o_stack_pointer(sp),
    .o_condition_code_reg(condition_code_reg), .o_reset_source_status(status));
  mem_bus_model u_mem_bus_model (.i_sys_clk(clk), .i_bus(bus), .o_rdata(rdata));
  always @(posedge clk) begin
    if (bus.rd === 1'b1 || bus.wr === 1'b1) got.push_back(bus);
    if (ctx_load === 1'b1) ctx_seen = octx;
    if (qv === 1'b1) qv_cnt++;
  end
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  task automatic final_report();
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string name, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wait_busy();
    int i;
    for (i = 0; i < 200 && busy !== 1'b1; i++) @(posedge clk);
    if (i == 200) begin error_cnt++; final_report(); end
  endtask
  task automatic wait_run();
    int i;
    for (i = 0; i < 200 && run !== 1'b1; i++) @(posedge clk);
    if (i == 200) begin error_cnt++; final_report(); end
  endtask
  task automatic clear();
    @(negedge clk);
    got.delete();
    exp_q.delete();
    qv_cnt = 0;
  endtask
  task automatic unmask();
    @(posedge clk);
    ccr_wr <= 1'b1;
    ccr_wdata <= 8'h60;
    @(posedge clk);
    ccr_wr <= 1'b0;
  endtask
  task automatic enter(input logic [7:0] p, input logic t, input logic r);
    @(posedge clk);
    pend <= p;
    software_trap <= t;
    return_from_interrupt <= r;
    wait_busy();
    @(posedge clk);
    {software_trap, return_from_interrupt} <= 2'b00;
    pend <= 8'h00;
    wait_run();
  endtask
  task automatic push_stack(input logic [15:0] s);
    logic [7:0] d[5];
    d = '{8'h44, 8'h33, 8'h22, 8'h11, 8'h60};
    for (int i = 0; i < 5; i++) exp_q.push_back('{addr:s - 16'(i), wdata:d[i], rd:1'b0, wr:1'b1});
  endtask
  task automatic push_vec(input logic [15:0] v);
    logic [15:0] t;
    t = {mem(v), mem(v + 16'h0001)};
    exp_q.push_back('{addr:v, wdata:8'h00, rd:1'b1, wr:1'b0});
    exp_q.push_back('{addr:v + 16'h0001, wdata:8'h00, rd:1'b1, wr:1'b0});
    for (int i = 0; i < 3; i++) exp_q.push_back('{addr:t + 16'(i), wdata:8'h00, rd:1'b1, wr:1'b0});
  endtask
  task automatic check_seq();
    @(negedge clk);
    check("bus count", 40'(exp_q.size()), 40'(got.size()));
    check("queue valid pulses", 40'h1, 40'(qv_cnt));
    for (int i = 0; i < exp_q.size() && i < got.size(); i++) begin
      check("bus addr", 40'(exp_q[i].addr), 40'(got[i].addr));
      check("bus kind", 40'({exp_q[i].rd, exp_q[i].wr}), 40'({got[i].rd, got[i].wr}));
      if (exp_q[i].wr) check("bus wdata", 40'(exp_q[i].wdata), 40'(got[i].wdata));
    end
  endtask
  task automatic entry_ok(input logic [7:0] p, input logic t, input logic [15:0] v);
    clear();
    enter(p, t, 1'b0);
    push_stack(sp_e);
    push_vec(v);
    check_seq();
    sp_e = sp_e - 16'h0005;
    @(negedge clk);
    check("stack pointer", 40'(sp_e), 40'(sp));
    check("mask bit", 40'h1, 40'(condition_code_reg[cpu_entry_pkg::CCR_I_BIT]));
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("reset outputs", 40'h7, 40'({abort, periph, hiz}));
    check("stack pointer", 40'(cpu_entry_pkg::STACK_RESET), 40'(sp));
    check("ccr", 40'(cpu_entry_pkg::CCR_RESET), 40'(condition_code_reg));
    clear();
    @(posedge clk);
    rst <= 1'b0;
    wait_run();
    push_vec(cpu_entry_pkg::RESET_VEC_HI);
    check_seq();
    sp_e = cpu_entry_pkg::STACK_RESET;
    foreach (rows[r]) begin
      unmask();
      entry_ok(rows[r].pend, 1'b0, rows[r].vec);
      clear();
      enter(8'h00, 1'b0, 1'b1);
      @(negedge clk);
      check("popped context", {mem(sp_e + 16'h0001), mem(sp_e + 16'h0002),
        mem(sp_e + 16'h0003), mem(sp_e + 16'h0004), mem(sp_e + 16'h0005)}, ctx_seen);
      sp_e = sp_e + 16'h0005;
      @(negedge clk);
      check("stack pointer", 40'(sp_e), 40'(sp));
    end
    // no boundary, then masked: nothing may reach the bus
    unmask();
    clear();
    @(posedge clk);
    bnd <= 1'b0;
    pend <= 8'h01;
    repeat (10) @(posedge clk);
    check("bus idle", 40'h0, 40'(got.size()));
    bnd <= 1'b1;
    entry_ok(8'h01, 1'b0, 16'hfffa);
    clear();
    @(posedge clk);
    pend <= 8'h01;
    repeat (10) @(posedge clk);
    check("bus idle", 40'h0, 40'(got.size()));
    entry_ok(8'h01, 1'b1, cpu_entry_pkg::SWI_VEC_HI);
    unmask();
    entry_ok(8'h02, 1'b0, 16'hfff8);
    for (int s = 0; s < 7; s++) begin
      unmask();
      @(posedge clk);
      pend <= 8'h01;
      wait_busy();
      @(posedge clk);
      if (s == cpu_entry_pkg::SRC_PIN) pin_n <= 1'b0;
      else rst_src[s] <= 1'b1;
      det_busy <= 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      check("abort", 40'h1, 40'(abort));
      @(posedge clk);
      rst_src <= 7'h00;
      pin_n <= 1'b1;
      pend <= 8'h00;
      repeat (8) @(posedge clk);
      @(negedge clk);
      check("abort held", 40'h1, 40'(abort));
      clear();
      @(posedge clk);
      det_busy <= 1'b0;
      wait_run();
      push_vec(cpu_entry_pkg::RESET_VEC_HI);
      check_seq();
      @(negedge clk);
      check("source status", 40'(7'h01 << s), 40'(status));
      check("stack pointer", 40'(cpu_entry_pkg::STACK_RESET), 40'(sp));
      check("ccr", 40'(cpu_entry_pkg::CCR_RESET), 40'(condition_code_reg));
      sp_e = cpu_entry_pkg::STACK_RESET;
    end
    final_report();
  end
endmodule // cpu_reset_interrupt_entry_test
